//--- design/breaker_failure_timer_cfg.svh
`ifndef BREAKER_FAILURE_TIMER_CFG_SVH
`define BREAKER_FAILURE_TIMER_CFG_SVH
// Register byte offsets
`define BFT_CTRL_OFS 8'h00
`define BFT_PHASE_THR_OFS 8'h04
`define BFT_RES_THR_OFS 8'h08
`define BFT_RETRIP_DLY_OFS 8'h0c
`define BFT_BF_DLY_OFS 8'h10
`define BFT_STATUS_OFS 8'h14
// Control register fields
`define BFT_CTRL_MODE_LSB 0
`define BFT_CTRL_SEL_LSB 4
`define BFT_CTRL_RETRIP_EN_BIT 8
// Status register fields
`define BFT_ST_CODE_LSB 0
`define BFT_ST_START_BIT 3
`define BFT_ST_RETRIP_BIT 4
`define BFT_ST_BF_BIT 5
`define BFT_ST_BLOCKED_BIT 6
`define BFT_ST_PICKUP_BIT 7
// Reset values: thresholds in 0.01 In and 0.001 In, delays in 5 ms steps
`define BFT_PHASE_THR_RST 12'h014
`define BFT_RES_THR_RST 16'h04b0
`define BFT_RETRIP_DLY_RST 19'h00014
`define BFT_BF_DLY_RST 19'h00028
`define BFT_RETRIP_EN_RST 1'b1
// Release ratio in percent, phase threshold scale to milli-In
`define BFT_RELEASE_PCT 24'h000061
`define BFT_PCT_FULL 24'h000064
`define BFT_PHASE_TO_MILLI 24'h00000a
// Program cycle: 5 ms at 25 MHz
`define BFT_CYCLE_US 5000
`define BFT_CLK_MHZ 25
`define BFT_CYCLE_CLKS (`BFT_CYCLE_US * `BFT_CLK_MHZ)
`define BFT_CYCLE_CNT_W 20
`endif

//--- design/breaker_failure_pkg.sv
`include "breaker_failure_timer_cfg.svh"
package breaker_failure_pkg;
  typedef enum logic [3:0] {
    MODE_CUR, MODE_DO, MODE_SIG, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
    MODE_CUR_AND_SIG, MODE_CUR_OR_SIG, MODE_SIG_AND_DO, MODE_SIG_OR_DO,
    MODE_CUR_AND_SIG_AND_DO, MODE_CUR_OR_SIG_OR_DO
  } op_mode_t;
  typedef enum logic [1:0] {
    RES_UNUSED, RES_INPUT_ONE, RES_INPUT_TWO, RES_CALC
  } res_sel_t;
  typedef enum logic [2:0] {
    COND_NORMAL, COND_START, COND_RETRIP, COND_BF, COND_BLOCKED
  } cond_code_t;
  typedef enum {ST_IDLE, ST_STARTED, ST_BLOCKED} fsm_t;
  typedef struct packed {
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
    logic [15:0] residual_input_one;
    logic [15:0] residual_input_two;
    logic [15:0] calculated_residual;
  } meas_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic [1:0] blk_sync;
    logic [1:0] sig_sync;
    logic [1:0] do_sync;
    logic blk_sampled;
    logic [`BFT_CYCLE_CNT_W-1:0] cyc_cnt;
    logic [3:0] mode;
    res_sel_t residual_source_select;
    logic retrip_en;
    logic [11:0] phase_thr;
    logic [15:0] res_thr;
    logic [18:0] retrip_delay;
    logic [18:0] bf_delay;
    logic [3:0] picked;
    fsm_t fsm;
    logic [18:0] rt_cnt;
    logic [18:0] bf_cnt;
    logic retrip;
    logic bf;
    logic ack;
    logic [31:0] rdata;
  } state_t;
endpackage : breaker_failure_pkg

//--- design/breaker_failure_timer.sv
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "breaker_failure_timer_cfg.svh"
module breaker_failure_timer
  import breaker_failure_pkg::*;
#(
  parameter int CYCLE_CLKS = `BFT_CYCLE_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire meas_t meas_i,
  input wire logic block_i,
  input wire logic signal_trip_i,
  input wire logic relay_monitor_i,
  output logic start_o,
  output logic retrip_o,
  output logic breaker_failure_output_o,
  output logic blocked_o
);
  localparam logic [`BFT_CYCLE_CNT_W-1:0] CYC_LAST = `BFT_CYCLE_CNT_W'(CYCLE_CLKS - 1);

  state_t q, d;
  logic tick;
  logic cur_pick;
  logic trig;
  logic run;
  logic [31:0] ctrl_rd;
  logic [31:0] status_rd;
  cond_code_t code;

  // Hysteresis comparator, all values scaled to milli-In times percent
  function automatic logic level_next(input logic [15:0] m, input logic [23:0] thr_milli,
                                      input logic prev);
    logic [23:0] m_pct;
    logic [23:0] thr_pct;
    logic [23:0] rel_pct;
    m_pct = 24'(m) * `BFT_PCT_FULL;
    thr_pct = thr_milli * `BFT_PCT_FULL;
    rel_pct = thr_milli * `BFT_RELEASE_PCT;
    if (m_pct > thr_pct)
      level_next = 1'b1;
    else if (m_pct < rel_pct)
      level_next = 1'b0;
    else
      level_next = prev;
  endfunction : level_next

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    lane_merge = r;
  endfunction : lane_merge

  assign tick = (q.cyc_cnt == '0);
  assign cur_pick = |q.picked;

  // Starting condition: trig raises start, run lets counters advance
  always_comb
  begin
    logic sg;
    logic dq;
    sg = q.sig_sync[1];
    dq = q.do_sync[1];
    unique case (q.mode)
      MODE_DO: trig = dq;
      MODE_SIG: trig = sg;
      MODE_CUR_AND_DO: trig = cur_pick;
      MODE_CUR_OR_DO: trig = cur_pick | dq;
      MODE_CUR_AND_SIG: trig = cur_pick & sg;
      MODE_CUR_OR_SIG: trig = cur_pick | sg;
      MODE_SIG_AND_DO: trig = sg;
      MODE_SIG_OR_DO: trig = sg | dq;
      MODE_CUR_AND_SIG_AND_DO: trig = cur_pick & sg;
      MODE_CUR_OR_SIG_OR_DO: trig = cur_pick | sg | dq;
      default: trig = cur_pick;
    endcase
    // Relay-gated modes keep the counters at zero until the relay control is seen
    run = trig;
    if (q.mode == MODE_CUR_AND_DO || q.mode == MODE_SIG_AND_DO || q.mode == MODE_CUR_AND_SIG_AND_DO)
      run = trig & dq;
  end

  always_comb
  begin
    if (q.fsm == ST_BLOCKED)
      code = COND_BLOCKED;
    else if (q.bf)
      code = COND_BF;
    else if (q.retrip)
      code = COND_RETRIP;
    else if (q.fsm == ST_STARTED)
      code = COND_START;
    else
      code = COND_NORMAL;
  end

  always_comb
  begin
    ctrl_rd = '0;
    ctrl_rd[`BFT_CTRL_MODE_LSB +: 4] = q.mode;
    ctrl_rd[`BFT_CTRL_SEL_LSB +: 2] = q.residual_source_select;
    ctrl_rd[`BFT_CTRL_RETRIP_EN_BIT] = q.retrip_en;
    status_rd = '0;
    status_rd[`BFT_ST_CODE_LSB +: 3] = code;
    status_rd[`BFT_ST_START_BIT] = start_o;
    status_rd[`BFT_ST_RETRIP_BIT] = q.retrip;
    status_rd[`BFT_ST_BF_BIT] = q.bf;
    status_rd[`BFT_ST_BLOCKED_BIT] = blocked_o;
    status_rd[`BFT_ST_PICKUP_BIT] = trig;
  end

  always_comb
  begin
    logic [15:0] res_m;
    logic wr;
    logic [31:0] w;
    res_m = '0;
    wr = 1'b0;
    w = '0;
    d = q;
    d.blk_sync = {q.blk_sync[0], block_i};
    d.sig_sync = {q.sig_sync[0], signal_trip_i};
    d.do_sync = {q.do_sync[0], relay_monitor_i};
    d.cyc_cnt = tick ? CYC_LAST : q.cyc_cnt - 1'b1;
    if (tick)
      d.blk_sampled = q.blk_sync[1];
    // Phase comparators share one threshold
    for (int i = 0; i < 3; i++)
      d.picked[i] = level_next(meas_i[95 - i*16 -: 16],
                               24'(q.phase_thr) * `BFT_PHASE_TO_MILLI,
                               q.picked[i]);
    unique case (q.residual_source_select)
      RES_INPUT_ONE: res_m = meas_i.residual_input_one;
      RES_INPUT_TWO: res_m = meas_i.residual_input_two;
      RES_CALC: res_m = meas_i.calculated_residual;
      RES_UNUSED: res_m = '0;
    endcase
    d.picked[3] = (q.residual_source_select != RES_UNUSED) &&
                  level_next(res_m, 24'(q.res_thr), q.picked[3]);
    // Sequencing once per program cycle
    if (tick)
    begin
      // Release and late blocking share one clearing path
      if (!trig || (q.fsm == ST_STARTED && q.blk_sync[1]))
      begin
        d.fsm = trig ? ST_BLOCKED : ST_IDLE;
        d.rt_cnt = '0;
        d.bf_cnt = '0;
        d.retrip = 1'b0;
        d.bf = 1'b0;
      end
      else
      begin
        unique case (q.fsm)
          ST_IDLE:
            d.fsm = q.blk_sync[1] ? ST_BLOCKED : ST_STARTED;
          ST_STARTED:
          begin
            if (!run)
            begin
              d.rt_cnt = '0;
              d.bf_cnt = '0;
            end
            else
            begin
              // Both timers advance from the same condition, saturating
              if (q.rt_cnt != '1)
                d.rt_cnt = q.rt_cnt + 1'b1;
              if (q.bf_cnt != '1)
                d.bf_cnt = q.bf_cnt + 1'b1;
              if (q.retrip_en && (q.rt_cnt >= q.retrip_delay))
                d.retrip = 1'b1;
              if (q.bf_cnt >= q.bf_delay)
                d.bf = 1'b1;
            end
          end
          ST_BLOCKED:
            d.fsm = ST_BLOCKED;
        endcase
      end
    end
    if (!q.retrip_en)
      d.retrip = 1'b0;
    // Wishbone slave, one wait state, settings take effect live
    d.ack = wb_i.cyc && wb_i.stb && !q.ack;
    wr = d.ack && wb_i.we;
    if (d.ack && !wb_i.we)
    begin
      unique case (wb_i.adr)
        `BFT_CTRL_OFS: d.rdata = ctrl_rd;
        `BFT_PHASE_THR_OFS: d.rdata = 32'(q.phase_thr);
        `BFT_RES_THR_OFS: d.rdata = 32'(q.res_thr);
        `BFT_RETRIP_DLY_OFS: d.rdata = 32'(q.retrip_delay);
        `BFT_BF_DLY_OFS: d.rdata = 32'(q.bf_delay);
        `BFT_STATUS_OFS: d.rdata = status_rd;
        default: d.rdata = '0;
      endcase
    end
    if (wr)
    begin
      unique case (wb_i.adr)
        `BFT_CTRL_OFS:
        begin
          w = lane_merge(ctrl_rd, wb_i.dat, wb_i.sel);
          d.mode = w[`BFT_CTRL_MODE_LSB +: 4];
          d.residual_source_select = res_sel_t'(w[`BFT_CTRL_SEL_LSB +: 2]);
          d.retrip_en = w[`BFT_CTRL_RETRIP_EN_BIT];
        end
        `BFT_PHASE_THR_OFS:
        begin
          w = lane_merge(32'(q.phase_thr), wb_i.dat, wb_i.sel);
          d.phase_thr = w[11:0];
        end
        `BFT_RES_THR_OFS:
        begin
          w = lane_merge(32'(q.res_thr), wb_i.dat, wb_i.sel);
          d.res_thr = w[15:0];
        end
        `BFT_RETRIP_DLY_OFS:
        begin
          w = lane_merge(32'(q.retrip_delay), wb_i.dat, wb_i.sel);
          d.retrip_delay = w[18:0];
        end
        `BFT_BF_DLY_OFS:
        begin
          w = lane_merge(32'(q.bf_delay), wb_i.dat, wb_i.sel);
          d.bf_delay = w[18:0];
        end
        default: w = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.retrip_en <= `BFT_RETRIP_EN_RST;
      q.phase_thr <= `BFT_PHASE_THR_RST;
      q.res_thr <= `BFT_RES_THR_RST;
      q.retrip_delay <= `BFT_RETRIP_DLY_RST;
      q.bf_delay <= `BFT_BF_DLY_RST;
      q.fsm <= ST_IDLE;
    end
    else
      q <= d;
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign start_o = (q.fsm == ST_STARTED);
  assign blocked_o = (q.fsm == ST_BLOCKED);
  assign retrip_o = q.retrip;
  assign breaker_failure_output_o = q.bf;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_unblocked_pick;
    tick && trig && q.fsm == ST_IDLE && !q.blk_sync[1];
  endsequence
  sequence s_blocked_pick;
    tick && trig && q.fsm == ST_IDLE && q.blk_sync[1];
  endsequence

  property p_start_on_pick;
    s_unblocked_pick |=> start_o && !blocked_o;
  endproperty
  a_start_on_pick: assert property (p_start_on_pick)
    else $error("start not raised on unblocked pick-up");

  property p_block_on_pick;
    s_blocked_pick |=> blocked_o && !start_o && !retrip_o && !breaker_failure_output_o;
  endproperty
  a_block_on_pick: assert property (p_block_on_pick)
    else $error("blocked not raised on blocked pick-up");

  property p_late_block;
    tick && trig && start_o && q.blk_sync[1]
      |=> !start_o && q.rt_cnt == '0 && q.bf_cnt == '0 && !breaker_failure_output_o;
  endproperty
  a_late_block: assert property (p_late_block)
    else $error("late blocking did not drop start");

  property p_release_clears;
    tick && !trig |=> !start_o && !retrip_o && !breaker_failure_output_o && q.bf_cnt == '0;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("release did not clear timers");

  property p_retrip_time;
    tick && start_o && !q.blk_sync[1] && trig && run && q.retrip_en &&
      q.rt_cnt >= q.retrip_delay |=> retrip_o;
  endproperty
  a_retrip_time: assert property (p_retrip_time)
    else $error("retrip missing after delay");

  property p_bf_early;
    !breaker_failure_output_o ##1 breaker_failure_output_o |-> $past(q.bf_cnt) >= q.bf_delay;
  endproperty
  a_bf_early: assert property (p_bf_early)
    else $error("breaker-failure output before its delay");

  property p_retrip_disabled;
    !q.retrip_en |=> !retrip_o;
  endproperty
  a_retrip_disabled: assert property (p_retrip_disabled)
    else $error("retrip active while disabled");

  property p_halt_and_do;
    tick && start_o && !run && q.mode == MODE_CUR_AND_DO |=> q.rt_cnt == '0 && q.bf_cnt == '0;
  endproperty
  a_halt_and_do: assert property (p_halt_and_do)
    else $error("counters ran without relay in AND mode");

  property p_count_step;
    !tick && !$rose(rst_i) |=> $stable(q.rt_cnt) && $stable(q.bf_cnt);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter moved between program cycles");

  property p_wb_ack;
    wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not a single cycle after request");

endmodule : breaker_failure_timer

//--- dv/feeder_side_model.sv
`timescale 1ns/1ps
module feeder_side_model
  import breaker_failure_pkg::*;
#(
  parameter int CLEAR_CLKS = 6
) (
  input wire logic clk_i,
  input wire logic [1:0] ph_sel_i,
  input wire logic [15:0] ph_lvl_i,
  input wire logic [1:0] res_route_i,
  input wire logic [15:0] res_lvl_i,
  input wire logic trip_cmd_i,
  input wire logic relay_cmd_i,
  input wire logic coil_works_i,
  input wire logic retrip_i,
  output meas_t meas_o,
  output logic signal_trip_o,
  output logic relay_monitor_o
);
  int wait_q = 0;
  logic cleared_q = 1'b0;
  assign signal_trip_o = trip_cmd_i;
  assign relay_monitor_o = relay_cmd_i;
  // Redundant coil opens the breaker a fixed time after retrip
  always_ff @(posedge clk_i)
  begin
    if (!coil_works_i)
    begin
      wait_q <= 0;
      cleared_q <= 1'b0;
    end
    else if (retrip_i && wait_q < CLEAR_CLKS)
      wait_q <= wait_q + 1;
    else if (wait_q == CLEAR_CLKS)
      cleared_q <= 1'b1;
  end
  always_comb
  begin
    meas_o = '0;
    if (!cleared_q)
    begin
      case (ph_sel_i)
        2'h0: meas_o.phase_a = ph_lvl_i;
        2'h1: meas_o.phase_b = ph_lvl_i;
        default: meas_o.phase_c = ph_lvl_i;
      endcase
      case (res_route_i)
        2'h1: meas_o.residual_input_one = res_lvl_i;
        2'h2: meas_o.residual_input_two = res_lvl_i;
        2'h3: meas_o.calculated_residual = res_lvl_i;
        default: meas_o.phase_a = meas_o.phase_a;
      endcase
    end
  end
endmodule : feeder_side_model

//--- dv/tb.sv
`timescale 1ns/1ps
`include "breaker_failure_timer_cfg.svh"
module tb;
  import breaker_failure_pkg::*;
  localparam int CC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_q = '0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic start_o;
  logic retrip_o;
  logic bf_o;
  logic blocked_o;
  meas_t meas;
  logic sig;
  logic relay;
  logic [1:0] psel_q = 2'h0;
  logic [15:0] plvl_q = 16'h0000;
  logic [1:0] route_q = 2'h0;
  logic [15:0] rlvl_q = 16'h0000;
  logic trip_q = 1'b0;
  logic relay_q = 1'b0;
  logic coil_q = 1'b0;
  logic block_q = 1'b0;
  logic [3:0] outs;
  int cyc_n = 0;
  int fails = 0;
  int total_checks = 0;
  int t0;
  int t1;
  int t2;
  assign outs = {blocked_o, bf_o, retrip_o, start_o};
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  breaker_failure_timer #(.CYCLE_CLKS(CC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_i(meas), .block_i(block_q),
    .signal_trip_i(sig), .relay_monitor_i(relay), .start_o(start_o), .retrip_o(retrip_o),
    .breaker_failure_output_o(bf_o), .blocked_o(blocked_o));
  feeder_side_model u_feed (.clk_i(clk_i), .ph_sel_i(psel_q), .ph_lvl_i(plvl_q),
    .res_route_i(route_q), .res_lvl_i(rlvl_q), .trip_cmd_i(trip_q), .relay_cmd_i(relay_q),
    .coil_works_i(coil_q), .retrip_i(retrip_o), .meas_o(meas), .signal_trip_o(sig),
    .relay_monitor_o(relay));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) fails++;
    rd = wb_dat_o;
    wb_q <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wo(input int i, input logic v, input int lim, output int t);
    int n;
    n = 0;
    @(posedge clk_i);
    while (outs[i] !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    t = cyc_n;
    chk({31'h0, outs[i]}, {31'h0, v});
  endtask : wo
  task automatic hold(input int i, input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (outs[i] !== v) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask : hold
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(`BFT_CTRL_OFS, 32'h100);
    rdchk(`BFT_PHASE_THR_OFS, 32'h14);
    rdchk(`BFT_RES_THR_OFS, 32'h4b0);
    rdchk(`BFT_RETRIP_DLY_OFS, 32'h14);
    rdchk(`BFT_BF_DLY_OFS, 32'h28);
    rdchk(8'h40, 32'h0);
    wb(1'b1, `BFT_STATUS_OFS, 32'hff);
    rdchk(`BFT_STATUS_OFS, 32'h0);
    wb(1'b1, `BFT_RETRIP_DLY_OFS, 32'h2);
    wb(1'b1, `BFT_BF_DLY_OFS, 32'h5);
    rdchk(`BFT_BF_DLY_OFS, 32'h5);
    for (int p = 0; p < 3; p++)
    begin
      psel_q <= p[1:0];
      plvl_q <= 16'd201;
      wo(0, 1'b1, 40, t0);
      plvl_q <= 16'd195;
      repeat (3) @(posedge clk_i);
      wb(1'b0, `BFT_STATUS_OFS, 32'h0);
      chk(rd & 32'h80, 32'h80);
      plvl_q <= 16'd193;
      wo(0, 1'b0, 40, t0);
      chk({28'h0, outs}, 32'h0);
    end
    psel_q <= 2'h0;
    plvl_q <= 16'd1000;
    wo(0, 1'b1, 40, t0);
    wo(1, 1'b1, 60, t1);
    wo(2, 1'b1, 60, t2);
    chk(t2 - t1, 3 * CC);
    chk(32'(t1 - t0 == 2 * CC || t1 - t0 == 3 * CC), 32'h1);
    rdchk(`BFT_STATUS_OFS, 32'hbb);
    plvl_q <= 16'h0000;
    wo(0, 1'b0, 40, t0);
    chk({28'h0, outs}, 32'h0);
    coil_q <= 1'b1;
    plvl_q <= 16'd1000;
    wo(1, 1'b1, 80, t1);
    rdchk(`BFT_STATUS_OFS, 32'h9a);
    wo(0, 1'b0, 40, t0);
    chk({31'h0, bf_o}, 32'h0);
    plvl_q <= 16'h0000;
    coil_q <= 1'b0;
    wb(1'b1, `BFT_CTRL_OFS, 32'h0);
    plvl_q <= 16'd1000;
    wo(2, 1'b1, 80, t2);
    chk({31'h0, retrip_o}, 32'h0);
    plvl_q <= 16'h0000;
    wo(0, 1'b0, 40, t0);
    wb(1'b1, `BFT_CTRL_OFS, 32'h100);
    block_q <= 1'b1;
    repeat (2 * CC) @(posedge clk_i);
    plvl_q <= 16'd1000;
    wo(3, 1'b1, 40, t0);
    hold(1, 1'b0, 6 * CC);
    chk({31'h0, start_o}, 32'h0);
    rdchk(`BFT_STATUS_OFS, 32'hc4);
    plvl_q <= 16'h0000;
    block_q <= 1'b0;
    wo(3, 1'b0, 40, t0);
    plvl_q <= 16'd1000;
    wo(0, 1'b1, 40, t0);
    block_q <= 1'b1;
    wo(0, 1'b0, 20, t1);
    chk({28'h0, outs}, 32'h8);
    plvl_q <= 16'h0000;
    block_q <= 1'b0;
    wo(3, 1'b0, 40, t0);
    wb(1'b1, `BFT_CTRL_OFS, 32'h103);
    plvl_q <= 16'd1000;
    wo(0, 1'b1, 40, t0);
    hold(1, 1'b0, 10 * CC);
    relay_q <= 1'b1;
    wo(1, 1'b1, 60, t1);
    relay_q <= 1'b0;
    plvl_q <= 16'h0000;
    wo(0, 1'b0, 40, t0);
    for (int m = 1; m < 5; m++)
    begin
      if (m == 3) continue;
      wb(1'b1, `BFT_CTRL_OFS, 32'h100 | m);
      trip_q <= (m == 2);
      relay_q <= (m != 2);
      wo(0, 1'b1, 40, t0);
      trip_q <= 1'b0;
      relay_q <= 1'b0;
      wo(0, 1'b0, 40, t0);
    end
    rlvl_q <= 16'd1300;
    for (int r = 1; r < 4; r++)
    begin
      route_q <= r[1:0];
      wb(1'b1, `BFT_CTRL_OFS, 32'h100 | (r << 4));
      wo(0, 1'b1, 40, t0);
      wb(1'b1, `BFT_CTRL_OFS, 32'h100 | ((r % 3 + 1) << 4));
      wo(0, 1'b0, 40, t0);
    end
    wb(1'b1, `BFT_CTRL_OFS, 32'h100);
    hold(0, 1'b0, 3 * CC);
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_sim();
  end
endmodule : tb
